// [logic/cub_unbalance_stage.sv]
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "cub_cfg.svh"

module cub_unbalance_stage #(
    parameter int           MS_TICKS = `CUB_MS_NS / `CUB_CLK_PERIOD_NS,
    parameter logic [1:0]   STAGE_ID = 2'h0,
    parameter int           LOG_DEPTH = `CUB_LOG_DEPTH
) (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire cub_pkg::cub_meas_t  measSide1,
    input  wire cub_pkg::cub_meas_t  measSide2,
    input  wire logic                measValid,
    input  wire logic                blockIn,
    input  wire logic [2:0]          settingGroup,
    output logic                     startOut,
    output logic                     tripOut,
    output logic                     blockedOut,
    output cub_pkg::cub_cond_t       condition,
    output cub_pkg::cub_event_t      eventOut
);

    localparam int PRE_TRIG  = `CUB_PRE_TRIG_MS / `CUB_MEAS_MS;
    localparam int PRE_FAULT = `CUB_PRE_FAULT_MS / `CUB_MEAS_MS;
    localparam int MS_W = $clog2(MS_TICKS + 1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Hysteresis compare shared by both operating quantities
    function automatic logic overSetting(input logic [47:0] q, input logic [47:0] lim, input logic active);
        logic [55:0] lhs;
        logic [55:0] rhs;
        lhs = {8'h00, q} * 56'd`CUB_FULL_PCT;
        rhs = {8'h00, lim} * 56'd`CUB_RESET_PCT;
        overSetting = active ? (lhs >= rhs) : (q > lim);
    endfunction

    function automatic logic [31:0] writeMerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[8*i +: 8] = dat[8*i +: 8];
            end
        end
        writeMerge = res;
    endfunction

    function automatic logic [31:0] logWord(input cub_pkg::cub_log_t e, input logic [2:0] idx);
        case (idx)
            3'h0: logWord = e.stamp;
            3'h1: logWord = {27'h0, e.group, e.kind};
            3'h2: logWord = {e.preTrig, e.fault};
            3'h3: logWord = {e.preFault, e.meas.posMag};
            3'h4: logWord = {e.meas.negMag, e.meas.zeroMag};
            3'h5: logWord = {e.meas.posAng, e.meas.negAng};
            3'h6: logWord = {e.meas.zeroAng, 16'h0000};
            default: logWord = e.remaining;
        endcase
    endfunction

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic [31:0] ctrl_r;
    logic [15:0] negSet_r;
    logic [15:0] ratioSet_r;
    logic [15:0] minLoad_r;
    logic [31:0] delayMs_r;
    logic [31:0] kVal_r;
    logic [5:0]  evtMask_r;
    logic [3:0]  logSel_r;
    logic [15:0] cntStart_r;
    logic [15:0] cntTrip_r;
    logic [15:0] cntBlk_r;
    logic [3:0]  logHead_r;
    logic [31:0] remaining;
    logic        pickup_r;
    cub_pkg::cub_log_t logMem [LOG_DEPTH];

    logic        busReq;
    logic        busWr;
    logic        clrCnt;
    logic [31:0] rdData;
    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign busWr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;
    assign clrCnt = busWr && wb_adr_i == `CUB_OFS_CTRL && wb_sel_i[3] && wb_dat_i[`CUB_CTRL_CLR_CNT];

    always_comb begin
        rdData = 32'h0000_0000;
        case (wb_adr_i)
            `CUB_OFS_CTRL:      rdData = {1'b0, ctrl_r[30:0]};
            `CUB_OFS_NEG_SET:   rdData = {16'h0, negSet_r};
            `CUB_OFS_RATIO_SET: rdData = {16'h0, ratioSet_r};
            `CUB_OFS_MIN_LOAD:  rdData = {16'h0, minLoad_r};
            `CUB_OFS_DELAY:     rdData = delayMs_r;
            `CUB_OFS_KVAL:      rdData = kVal_r;
            `CUB_OFS_EVT_MASK:  rdData = {26'h0, evtMask_r};
            `CUB_OFS_STATUS:    rdData = {22'h0, pickup_r, blockedOut, tripOut, startOut, condition, logHead_r};
            `CUB_OFS_CNT_START: rdData = {16'h0, cntStart_r};
            `CUB_OFS_CNT_TRIP:  rdData = {16'h0, cntTrip_r};
            `CUB_OFS_CNT_BLK:   rdData = {16'h0, cntBlk_r};
            `CUB_OFS_LOG_SEL:   rdData = {28'h0, logSel_r};
            default: begin
                if (wb_adr_i >= `CUB_OFS_LOG_BASE && wb_adr_i <= `CUB_OFS_LOG_LAST && logSel_r < LOG_DEPTH) begin
                    rdData = logWord(logMem[logSel_r], wb_adr_i[4:2] - 3'h4);
                end
            end
        endcase
    end

    // One-cycle answer to every address; unmapped ones read zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? rdData : 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_r     <= `CUB_RST_CTRL;
            negSet_r   <= `CUB_RST_NEG_SET;
            ratioSet_r <= `CUB_RST_RATIO_SET;
            minLoad_r  <= `CUB_RST_MIN_LOAD;
            delayMs_r  <= `CUB_RST_DELAY;
            kVal_r     <= `CUB_RST_KVAL;
            evtMask_r  <= `CUB_RST_EVT_MASK;
            logSel_r   <= 4'h0;
        end else if (busWr) begin
            case (wb_adr_i)
                `CUB_OFS_CTRL:      ctrl_r <= writeMerge(ctrl_r, wb_dat_i & 32'h7fff_ffff, wb_sel_i);
                `CUB_OFS_NEG_SET:   negSet_r <= 16'(writeMerge({16'h0, negSet_r}, wb_dat_i, wb_sel_i));
                `CUB_OFS_RATIO_SET: ratioSet_r <= 16'(writeMerge({16'h0, ratioSet_r}, wb_dat_i, wb_sel_i));
                `CUB_OFS_MIN_LOAD:  minLoad_r <= 16'(writeMerge({16'h0, minLoad_r}, wb_dat_i, wb_sel_i));
                `CUB_OFS_DELAY:     delayMs_r <= writeMerge(delayMs_r, wb_dat_i, wb_sel_i);
                `CUB_OFS_KVAL:      kVal_r <= writeMerge(kVal_r, wb_dat_i, wb_sel_i);
                `CUB_OFS_EVT_MASK:  evtMask_r <= 6'(writeMerge({26'h0, evtMask_r}, wb_dat_i, wb_sel_i));
                `CUB_OFS_LOG_SEL:   logSel_r <= 4'(writeMerge({28'h0, logSel_r}, wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Settings decode
    // ----------------------------------------
    logic                  ratioMode;
    cub_pkg::cub_delay_t   dlyMode;
    cub_pkg::cub_node_t    nodeMode;
    cub_pkg::cub_cond_t    forceCond;
    cub_pkg::cub_meas_t    meas;
    assign ratioMode = ctrl_r[`CUB_CTRL_RATIO];
    assign dlyMode   = cub_pkg::cub_delay_t'(ctrl_r[`CUB_CTRL_DLY_HI:`CUB_CTRL_DLY_LO]);
    assign nodeMode  = cub_pkg::cub_node_t'(ctrl_r[`CUB_CTRL_NODE_HI:`CUB_CTRL_NODE_LO]);
    assign forceCond = cub_pkg::cub_cond_t'(ctrl_r[`CUB_CTRL_FORCE_HI:`CUB_CTRL_FORCE_LO]);
    assign meas      = ctrl_r[`CUB_CTRL_SIDE] ? measSide2 : measSide1;

    // ----------------------------------------
    // Pick-up and blocking
    // ----------------------------------------
    logic [47:0] quantity;
    logic [47:0] threshold;
    logic        loadOk;
    logic        pickNxt;
    logic        effBlock;
    logic        start_r;
    logic        blk_r;
    logic        trip_r;
    logic        startNxt;
    logic        timeUp;

    always_comb begin
        if (ratioMode) begin
            quantity  = 48'(meas.negMag) * 48'd`CUB_RATIO_SCALE;
            threshold = 48'(ratioSet_r) * 48'(meas.posMag);
        end else begin
            quantity  = 48'(meas.negMag);
            threshold = 48'(negSet_r);
        end
    end

    assign loadOk  = meas.phaseA >= minLoad_r && meas.phaseB >= minLoad_r && meas.phaseC >= minLoad_r;
    assign pickNxt = overSetting(quantity, threshold, pickup_r) & (~ratioMode | loadOk);
    // Block input is looked at in the very cycle the new values land
    assign effBlock = blockIn | nodeMode == cub_pkg::CUB_NODE_BLOCKED
                    | nodeMode == cub_pkg::CUB_TEST_BLOCKED;
    assign startNxt = measValid ? (pickNxt & ~effBlock) : start_r;

    always_ff @(posedge sys_clk) begin
        if (srst || nodeMode == cub_pkg::CUB_OFF) begin
            pickup_r <= 1'b0;
            start_r  <= 1'b0;
            blk_r    <= 1'b0;
        end else if (measValid) begin
            pickup_r <= pickNxt;
            start_r  <= pickNxt & ~effBlock;
            blk_r    <= pickNxt & effBlock;
        end
    end

    // ----------------------------------------
    // Operate timing
    // ----------------------------------------
    logic [MS_W-1:0] msCnt_r;
    logic            msTick;
    logic [31:0]     stamp_r;
    logic [31:0]     elapsed_r;
    logic [47:0]     acc_r;
    logic [31:0]     negSq;
    logic [31:0]     setSq;
    logic [31:0]     curveStep;
    assign msTick = msCnt_r == MS_W'(MS_TICKS - 1);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            msCnt_r <= '0;
            stamp_r <= 32'h0000_0000;
        end else begin
            msCnt_r <= msTick ? '0 : msCnt_r + MS_W'(1);
            stamp_r <= stamp_r + 32'(msTick);
        end
    end

    assign negSq = 32'(meas.negMag) * 32'(meas.negMag);
    assign setSq = 32'(negSet_r) * 32'(negSet_r);
    // No positive divisor means no inverse-time progress toward a trip; the fixed delay still counts
    always_comb begin
        curveStep = 32'h0000_0000;
        if (ctrl_r[`CUB_CTRL_CURVE]) begin
            if (meas.negMag > negSet_r) curveStep = 32'(meas.negMag - negSet_r);
        end else if (negSq > setSq) begin
            curveStep = negSq - setSq;
        end
    end

    // Integrating the divisor over time equals k/divisor for a steady fault
    // and avoids a hardware divider
    always_ff @(posedge sys_clk) begin
        if (srst || !startNxt) begin
            elapsed_r <= 32'h0000_0000;
            acc_r     <= 48'h0;
        end else if (msTick) begin
            elapsed_r <= elapsed_r + 32'h0000_0001;
            acc_r     <= acc_r + 48'(curveStep);
        end
    end

    always_comb begin
        case (dlyMode)
            cub_pkg::CUB_INSTANT: timeUp = 1'b1;
            cub_pkg::CUB_FIXED:   timeUp = elapsed_r >= delayMs_r;
            cub_pkg::CUB_INVERSE: timeUp = acc_r >= 48'(kVal_r);
            default:              timeUp = 1'b0;
        endcase
    end

    assign remaining = (dlyMode == cub_pkg::CUB_FIXED && start_r && delayMs_r > elapsed_r)
                     ? delayMs_r - elapsed_r : 32'h0000_0000;

    always_ff @(posedge sys_clk) begin
        if (srst || nodeMode == cub_pkg::CUB_OFF) begin
            trip_r <= 1'b0;
        end else begin
            trip_r <= startNxt & (trip_r | timeUp);
        end
    end

    // ----------------------------------------
    // Outputs, forcing and condition
    // ----------------------------------------
    logic            oStart;
    logic            oTrip;
    logic            oBlk;
    always_comb begin
        oStart = start_r;
        oTrip  = trip_r & nodeMode != cub_pkg::CUB_TEST;
        oBlk   = blk_r;
        if (ctrl_r[`CUB_CTRL_FORCE_EN]) begin
            oStart = forceCond == cub_pkg::CUB_START || forceCond == cub_pkg::CUB_TRIP;
            oTrip  = forceCond == cub_pkg::CUB_TRIP;
            oBlk   = forceCond == cub_pkg::CUB_BLOCKED;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            startOut   <= 1'b0;
            tripOut    <= 1'b0;
            blockedOut <= 1'b0;
            condition  <= cub_pkg::CUB_NORMAL;
        end else begin
            startOut   <= oStart;
            tripOut    <= oTrip;
            blockedOut <= oBlk;
            if (oTrip)        condition <= cub_pkg::CUB_TRIP;
            else if (oStart)  condition <= cub_pkg::CUB_START;
            else if (oBlk)    condition <= cub_pkg::CUB_BLOCKED;
            else              condition <= cub_pkg::CUB_NORMAL;
        end
    end

    // ----------------------------------------
    // Events and counters
    // ----------------------------------------
    logic [2:0] rise;
    logic [2:0] fall;
    assign rise = {oBlk & ~blockedOut, oTrip & ~tripOut, oStart & ~startOut};
    assign fall = {~oBlk & blockedOut, ~oTrip & tripOut, ~oStart & startOut};

    // One event per cycle; trip rise outranks start, start outranks trip fall, trip fall outranks block
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            eventOut <= '0;
        end else begin
            eventOut <= '0;
            for (int k = 2; k >= 0; k--) begin
                if (rise[k] && evtMask_r[2*k]) begin
                    eventOut <= '{1'b1, STAGE_ID, cub_pkg::cub_ev_kind_t'(k), 1'b1};
                end else if (fall[k] && evtMask_r[2*k+1]) begin
                    eventOut <= '{1'b1, STAGE_ID, cub_pkg::cub_ev_kind_t'(k), 1'b0};
                end
            end
            if (rise[1] && evtMask_r[2]) eventOut <= '{1'b1, STAGE_ID, cub_pkg::CUB_EV_TRIP, 1'b1};
        end
    end

    // A count arriving with the clear survives as one
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cntStart_r <= 16'h0000;
            cntTrip_r  <= 16'h0000;
            cntBlk_r   <= 16'h0000;
        end else begin
            cntStart_r <= (clrCnt ? 16'h0000 : cntStart_r) + 16'(rise[0]);
            cntTrip_r  <= (clrCnt ? 16'h0000 : cntTrip_r) + 16'(rise[1]);
            cntBlk_r   <= (clrCnt ? 16'h0000 : cntBlk_r) + 16'(rise[2]);
        end
    end

    // ----------------------------------------
    // History and fault log
    // ----------------------------------------
    logic [15:0] hist [PRE_FAULT];
    logic [5:0]  histPtr_r;
    logic [5:0]  trigIdx;
    assign trigIdx = histPtr_r >= 6'(PRE_TRIG) ? histPtr_r - 6'(PRE_TRIG)
                                             : histPtr_r + 6'(PRE_FAULT - PRE_TRIG);

    // Slot at the write pointer holds the sample taken 200 ms ago
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            histPtr_r <= 6'h00;
        end else if (measValid) begin
            hist[histPtr_r] <= meas.negMag;
            histPtr_r       <= histPtr_r == 6'(PRE_FAULT - 1) ? 6'h00 : histPtr_r + 6'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            logHead_r <= 4'h0;
        end else if (|rise) begin
            logMem[logHead_r] <= '{stamp_r,
                                   rise[1] ? cub_pkg::CUB_EV_TRIP : rise[0] ? cub_pkg::CUB_EV_START
                                                                    : cub_pkg::CUB_EV_BLOCK,
                                   settingGroup, hist[trigIdx], meas.negMag, hist[histPtr_r],
                                   meas, remaining};
            logHead_r <= logHead_r == 4'(LOG_DEPTH - 1) ? 4'h0 : logHead_r + 4'h1;
        end
    end

endmodule

`default_nettype wire

// [logic/cub_cfg.svh]
`ifndef CUB_CFG_SVH
`define CUB_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CUB_OFS_CTRL      8'h00
`define CUB_OFS_NEG_SET   8'h04
`define CUB_OFS_RATIO_SET 8'h08
`define CUB_OFS_MIN_LOAD  8'h0c
`define CUB_OFS_DELAY     8'h10
`define CUB_OFS_KVAL      8'h14
`define CUB_OFS_EVT_MASK  8'h18
`define CUB_OFS_STATUS    8'h1c
`define CUB_OFS_CNT_START 8'h20
`define CUB_OFS_CNT_TRIP  8'h24
`define CUB_OFS_CNT_BLK   8'h28
`define CUB_OFS_LOG_SEL   8'h2c
`define CUB_OFS_LOG_BASE  8'h30
`define CUB_OFS_LOG_LAST  8'h4c

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define CUB_CTRL_RATIO    0
`define CUB_CTRL_SIDE     1
`define CUB_CTRL_DLY_LO   2
`define CUB_CTRL_DLY_HI   3
`define CUB_CTRL_CURVE    4
`define CUB_CTRL_NODE_LO  5
`define CUB_CTRL_NODE_HI  7
`define CUB_CTRL_FORCE_EN 8
`define CUB_CTRL_FORCE_LO 9
`define CUB_CTRL_FORCE_HI 10
`define CUB_CTRL_CLR_CNT  31

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CUB_RST_CTRL      32'h0000_0000
`define CUB_RST_NEG_SET   16'h0014
`define CUB_RST_RATIO_SET 16'h07d0
`define CUB_RST_MIN_LOAD  16'h000a
`define CUB_RST_DELAY     32'h0000_0064
`define CUB_RST_KVAL      32'h0001_0000
`define CUB_RST_EVT_MASK  6'h3f

// ----------------------------------------
// Timing, scaling and log depth
// ----------------------------------------
`define CUB_CLK_PERIOD_NS 50
`define CUB_MS_NS         1000000
`define CUB_MEAS_MS       5
`define CUB_PRE_TRIG_MS   20
`define CUB_PRE_FAULT_MS  200
`define CUB_RESET_PCT     97
`define CUB_FULL_PCT      100
`define CUB_RATIO_SCALE   10000
`define CUB_LOG_DEPTH     12

`endif

// [logic/cub_pkg.sv]
package cub_pkg;

    typedef enum logic [1:0] {CUB_NORMAL, CUB_START, CUB_TRIP, CUB_BLOCKED} cub_cond_t;
    typedef enum logic [2:0] {CUB_ON, CUB_NODE_BLOCKED, CUB_TEST, CUB_TEST_BLOCKED, CUB_OFF} cub_node_t;
    typedef enum logic [1:0] {CUB_INSTANT, CUB_FIXED, CUB_INVERSE} cub_delay_t;
    typedef enum logic [1:0] {CUB_EV_START, CUB_EV_TRIP, CUB_EV_BLOCK} cub_ev_kind_t;

    typedef struct packed {
        logic [15:0] posMag;
        logic [15:0] negMag;
        logic [15:0] zeroMag;
        logic [15:0] posAng;
        logic [15:0] negAng;
        logic [15:0] zeroAng;
        logic [15:0] phaseA;
        logic [15:0] phaseB;
        logic [15:0] phaseC;
    } cub_meas_t;

    typedef struct packed {
        logic         valid;
        logic [1:0]   stage;
        cub_ev_kind_t kind;
        logic         on;
    } cub_event_t;

    typedef struct packed {
        logic [31:0]  stamp;
        cub_ev_kind_t kind;
        logic [2:0]   group;
        logic [15:0]  preTrig;
        logic [15:0]  fault;
        logic [15:0]  preFault;
        cub_meas_t    meas;
        logic [31:0]  remaining;
    } cub_log_t;

endpackage

// [bench/cub_meas_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cub_meas_model #(
    parameter int PERIOD = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic [15:0]  negVal,
    input  wire logic [15:0]  posVal,
    input  wire logic [15:0]  phVal,
    input  wire logic         useSide2,
    input  wire logic         blkReq,
    output var cub_pkg::cub_meas_t measSide1,
    output var cub_pkg::cub_meas_t measSide2,
    output logic              measValid,
    output logic              blockIn
);
    int                 cnt;
    cub_pkg::cub_meas_t m;
    assign m = '{posVal, negVal, 16'h5, 16'hbb8, 16'h1770, 16'h2328, phVal, phVal, phVal};
    // Idle side shows the inverse, so picking the wrong side trips
    assign measSide1 = useSide2 ? ~m : m;
    assign measSide2 = useSide2 ? m : ~m;
    always_ff @(posedge sys_clk) begin
        cnt <= (srst || cnt == PERIOD - 1) ? 0 : cnt + 1;
        measValid <= !srst && cnt == PERIOD - 1;
    end
    // Block reaches the stage one clock after blkReq
    always_ff @(posedge sys_clk) blockIn <= blkReq;
endmodule
`default_nettype wire

// [bench/cub_unbalance_stage_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module cub_unbalance_stage_checker #(
    parameter logic [1:0] STAGE_ID = 2'h0
) (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic [31:0]         wb_dat_o,
    input  wire logic                wb_ack_o,
    input  wire logic                measValid,
    input  wire logic                startOut,
    input  wire logic                tripOut,
    input  wire logic                blockedOut,
    input  wire cub_pkg::cub_cond_t  condition,
    input  wire cub_pkg::cub_event_t eventOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    property p_dat0; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    property p_trst; tripOut |-> startOut; endproperty
    property p_bex; blockedOut |-> !startOut && !tripOut; endproperty
    property p_cond;
        condition == (tripOut ? cub_pkg::CUB_TRIP : startOut ? cub_pkg::CUB_START :
                      blockedOut ? cub_pkg::CUB_BLOCKED : cub_pkg::CUB_NORMAL);
    endproperty
    property p_srise; $rose(startOut) |-> $past(measValid, 2) || $past(wb_ack_o) || $past(wb_ack_o, 2); endproperty
    property p_evt;
        $rose(tripOut) |-> eventOut.valid && eventOut.kind == cub_pkg::CUB_EV_TRIP && eventOut.on
                           && eventOut.stage == STAGE_ID;
    endproperty
    property p_evs;
        $fell(startOut) && !$past(tripOut) && $past(measValid, 2)
            |-> eventOut.valid && eventOut.kind == cub_pkg::CUB_EV_START && !eventOut.on;
    endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
    a_dat0: assert property (p_dat0) else $error("read data outside ack");
    a_trst: assert property (p_trst) else $error("trip without start");
    a_bex: assert property (p_bex) else $error("blocked with start");
    a_cond: assert property (p_cond) else $error("condition mismatch");
    a_srise: assert property (p_srise) else $error("start outside cycle");
    a_evt: assert property (p_evt) else $error("trip event missing");
    a_evs: assert property (p_evs) else $error("start off event missing");
    c_trip: cover property ($rose(tripOut));
    c_blk: cover property ($rose(blockedOut));
    c_rel: cover property ($fell(startOut) && !$past(tripOut));
endmodule
bind cub_unbalance_stage cub_unbalance_stage_checker #(.STAGE_ID(STAGE_ID)) chk_i (
    .sys_clk(sys_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .measValid(measValid), .startOut(startOut), .tripOut(tripOut),
    .blockedOut(blockedOut), .condition(condition), .eventOut(eventOut));
`default_nettype wire

// [bench/tb_cub_unbalance_stage.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_cub_unbalance_stage;
    localparam int P = 8;
    localparam int MT = 4;
    localparam int D = 10;
    localparam logic [7:0] RA [8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h00, 8'h50};
    localparam logic [31:0] RV [8] = '{32'h14, 32'h7d0, 32'ha, 32'h64, 32'h10000, 32'h3f, 32'h0, 32'h0};
    localparam logic [31:0] CN [3] = '{32'h4, 32'h3, 32'h0};
    logic        sys_clk = 0, srst = 1, req = 0, we = 0, side2 = 0, blkReq = 0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, q, datO;
    logic [15:0] negVal = 16'h0, posVal = 16'h64, phVal = 16'h64;
    logic        ack, mv, blk, startOut, tripOut, blockedOut;
    cub_pkg::cub_meas_t  m1, m2;
    cub_pkg::cub_cond_t  cond;
    cub_pkg::cub_event_t ev;
    int          error_cnt = 0, compares = 0, n;
    cub_meas_model #(.PERIOD(P)) model (.sys_clk(sys_clk), .srst(srst), .negVal(negVal), .posVal(posVal),
        .phVal(phVal), .useSide2(side2), .blkReq(blkReq), .measSide1(m1), .measSide2(m2),
        .measValid(mv), .blockIn(blk));
    cub_unbalance_stage #(.MS_TICKS(MT)) dut (.sys_clk(sys_clk), .srst(srst), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(datO),
        .wb_ack_o(ack), .measSide1(m1), .measSide2(m2), .measValid(mv), .blockIn(blk),
        .settingGroup(3'h2), .startOut(startOut), .tripOut(tripOut), .blockedOut(blockedOut),
        .condition(cond), .eventOut(ev));
    initial forever #25 sys_clk = ~sys_clk;
    task end_sim();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        req <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        q = datO;
        req <= 0;
        if (ack !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
    endtask
    task st(input logic [31:0] e);
        wb(0, 8'h1c, 32'h0);
        chk(q & 32'h1f0, e);
    endtask
    task wsig(input int s, output int c);
        c = 0;
        while ((s == 0 ? startOut : tripOut) !== 1'b1 && c < 200) begin
            @(posedge sys_clk);
            c++;
        end
        if (c == 200) begin
            error_cnt++;
            end_sim();
        end
    endtask
    task idle(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    initial begin
        idle(16);
        srst <= 0;
        for (int i = 0; i < 8; i++) begin
            wb(0, RA[i], 32'h0);
            chk(q, RV[i]);
        end
        wb(1, 8'h10, D);
        wb(1, 8'h00, 32'h4);
        negVal <= 16'h19;
        wsig(0, n);
        wsig(1, n);
        chk({31'h0, n >= D * MT - 2 && n <= D * MT + 4}, 32'h1);
        st(32'he0);
        negVal <= 16'h14;
        idle(2 * P);
        st(32'he0);
        negVal <= 16'h13;
        idle(2 * P);
        st(32'h0);
        negVal <= 16'h19;
        wsig(0, n);
        st(32'h50);
        negVal <= 16'h0;
        idle(D * MT);
        st(32'h0);
        wb(1, 8'h14, 32'h708);
        wb(1, 8'h00, 32'h8);
        negVal <= 16'h19;
        wsig(0, n);
        wsig(1, n);
        chk({31'h0, n >= 8 * MT - 2 && n <= 8 * MT + 4}, 32'h1);
        negVal <= 16'h0;
        idle(2 * P);
        wb(1, 8'h00, 32'h0);
        negVal <= 16'h19;
        wsig(0, n);
        chk({31'h0, tripOut}, 32'h1);
        negVal <= 16'h0;
        idle(2 * P);
        for (int i = 0; i < 3; i++) begin
            wb(0, 8'h20 + 8'(4 * i), 32'h0);
            chk(q, CN[i]);
        end
        wb(1, 8'h00, 32'h8000_0000);
        wb(0, 8'h24, 32'h0);
        chk(q, 32'h0);
        wb(0, 8'h34, 32'h0);
        chk(q, 32'h8);
        wb(1, 8'h2c, 32'h1);
        wb(0, 8'h34, 32'h0);
        chk(q, 32'h9);
        wb(0, 8'h38, 32'h0);
        chk(q & 32'hffff, 32'h19);
        wb(0, 8'h1c, 32'h0);
        chk(q & 32'hf, 32'h6);
        blkReq <= 1;
        negVal <= 16'h19;
        idle(2 * P);
        st(32'h130);
        blkReq <= 0;
        negVal <= 16'h0;
        idle(2 * P);
        negVal <= 16'h19;
        wsig(0, n);
        blkReq <= 1;
        idle(2 * P);
        wb(0, 8'h1c, 32'h0);
        chk(q & 32'h40, 32'h0);
        blkReq <= 0;
        negVal <= 16'h1e;
        phVal <= 16'h5;
        wb(1, 8'h00, 32'h1);
        idle(3 * P);
        st(32'h0);
        phVal <= 16'h64;
        wsig(0, n);
        st(32'he0);
        negVal <= 16'h0;
        side2 <= 1;
        wb(1, 8'h00, 32'h2);
        idle(3 * P);
        st(32'h0);
        negVal <= 16'h19;
        wb(1, 8'h00, 32'h42);
        idle(3 * P);
        wb(0, 8'h1c, 32'h0);
        chk(q & 32'hc0, 32'h40);
        wb(1, 8'h00, 32'h82);
        idle(3 * P);
        st(32'h0);
        wb(1, 8'h00, 32'h500);
        st(32'he0);
        end_sim();
    end
endmodule
`default_nettype wire
